// ---- design/serial_channel_pkg.sv ----
// constants and carriers of the three-wire serial channel
package serial_channel_pkg;

  // register addresses
  localparam logic [15:0] ADDR_MODE     = 16'hff68;
  localparam logic [15:0] ADDR_SHIFT    = 16'hff69;
  localparam logic [15:0] ADDR_CONTROL  = 16'hff6a;
  localparam logic [15:0] ADDR_INTERVAL = 16'hff6b;
  localparam logic [15:0] ADDR_POINTER  = 16'hff6c;
  localparam logic [15:0] ADDR_STATUS   = 16'hff6d;
  localparam logic [15:0] ADDR_RAM_BASE = 16'hfac0;
  localparam int          RAM_DEPTH     = 64;

  // reset values
  localparam logic [7:0] MODE_RESET     = 8'h00;
  localparam logic [7:0] CONTROL_RESET  = 8'h00;
  localparam logic [7:0] INTERVAL_RESET = 8'h00;

  // mode register fields
  localparam int MODE_ENABLE_BIT = 7;
  localparam int MODE_ORDER_BIT  = 6;
  localparam int MODE_AUTO_BIT   = 5;
  localparam int MODE_CLKHI_BIT  = 1;
  localparam int MODE_CLKLO_BIT  = 0;
  localparam logic [7:0] MODE_WRITE_MASK = 8'he3;

  // control register fields
  localparam int CTRL_RX_BIT     = 7;
  localparam int CTRL_FAULT_BIT  = 4;
  localparam int CTRL_XFER_BIT   = 3;
  localparam int CTRL_STROBE_BIT = 2;
  localparam int CTRL_WAIT_BIT   = 1;
  localparam logic [7:0] CTRL_WRITE_MASK = 8'he7;

  // interval register fields
  localparam int IVL_ENABLE_BIT = 7;
  localparam logic [7:0] IVL_WRITE_MASK = 8'h9f;

  // status register field
  localparam int STAT_IRQ_BIT = 0;

  // timing: fx reference of the interval formula is 5 MHz
  localparam int CLK_PERIOD_NS = 25;
  localparam int GAP_UNIT_NS   = 25600;
  localparam int GAP_BASE_NS   = 11200;
  localparam int GAP_UNIT_CYC  =
    (GAP_UNIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int GAP_BASE_CYC  =
    (GAP_BASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [15:0] GAP_FREE_CYC = 16'h0002;
  localparam logic [3:0]  STROBE_CYC   = 4'h4;
  localparam logic [3:0]  BITS_PER_FRAME = 4'h8;

  // engine states
  typedef enum logic [4:0] {
    ST_IDLE  = 5'b00001,
    ST_LOAD  = 5'b00010,
    ST_SHIFT = 5'b00100,
    ST_DONE  = 5'b01000,
    ST_GAP   = 5'b10000
  } engine_state_t;

  // pin drive toward the partner
  typedef struct packed {
    logic sck;
    logic sckOe;
    logic so;
    logic soOe;
    logic strobe;
    logic strobeOe;
  } serial_pins_out_t;

endpackage

// ---- design/pin_sync.sv ----
// two-flop synchroniser for pin inputs
module pin_sync #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             rstN,
  // data
  input  wire logic [WIDTH-1:0] asyncIn,
  output      logic [WIDTH-1:0] syncOut
);

  logic [WIDTH-1:0] meta_q;

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      meta_q  <= '0;
      syncOut <= '0;
    end else begin
      meta_q  <= asyncIn;
      syncOut <= meta_q;
    end
  end

endmodule // pin_sync

// ---- design/serial_channel.sv ----
// three-wire serial channel with automatic buffer transfer
// Function
// - clock select high 0 external pin, 10 timer two, 11 prescaler
// - auto mode select 0 single byte, 1 automatic buffer transfer
// - mode bit 6 selects MSB first at 0, LSB first at 1
// - frames are 8 bits, each bit moved with the serial clock
// - shift on falling serial clock, output latch drives serial out
// - serial in sampled into shift register on rising serial clock
// - after eight bits shifting stops; irq flag sets then in single byte mode, after the last byte in auto mode
// - software write to shift register drives serial out low
// - bit order done by reversing bus path, shift direction fixed
// - write starts only when enabled and serial clock stopped
// - enabling after the write does not start a transfer
// - auto mode sends and stores buffer bytes, up to 64
// - auto mode drives strobe, and honours busy in hardware only while interval control is off
// - rx enable 0 in auto mode means transmit only, serial in left free; single byte mode always receives
// - transfer flag and fault flag are read only
// - interval control off inserts no programmed gap
// - reset clears mode, control and interval registers
// - interval on: gap of (n+1)*128 plus 56 fx periods
// - pointer decrements per byte, ends after 00h, flag clears
//
// Decided for this implementation: the plain strobed port.
module serial_channel #(
  parameter int GAP_UNIT_CYC = serial_channel_pkg::GAP_UNIT_CYC,
  parameter int GAP_BASE_CYC = serial_channel_pkg::GAP_BASE_CYC
) (
  // clock and reset
  input  wire logic                                 clk,
  input  wire logic                                 rst_n,
  // register port
  input  wire logic [15:0]                          addr,
  input  wire logic [7:0]                           wrData,
  input  wire logic                                 wrStrobe,
  input  wire logic                                 rdStrobe,
  output      logic [7:0]                           rdData,
  // internal clock sources, one-cycle ticks
  input  wire logic                                 timerTwoTick,
  input  wire logic                                 prescalerTick,
  // serial pins
  input  wire logic                                 serialClockPinIn,
  input  wire logic                                 serialInPin,
  input  wire logic                                 busyPinIn,
  output      serial_channel_pkg::serial_pins_out_t pinsOut,
  // event flag
  output      logic                                 channelIrqFlag
);

  ////////////////////////////////////////////////////////////////////////
  localparam int RAM_DEPTH = serial_channel_pkg::RAM_DEPTH;

  logic                              rstMeta_q;
  logic                              rstN;
  logic [2:0]                        pinSync;
  logic                              sckSync;
  logic                              siSync;
  logic                              busySync;
  logic                              sckPrev_q;
  logic [7:0]                        mode_q;
  logic [7:0]                        control_q;
  logic [7:0]                        interval_q;
  logic [5:0]                        pointer_q;
  logic [7:0]                        shift_q;
  logic                              soLatch_q;
  logic                              sckInt_q;
  logic [3:0]                        bitCnt_q;
  logic [15:0]                       gapCnt_q;
  logic [15:0]                       gapLoad;
  logic [3:0]                        strobeCnt_q;
  logic                              xfer_q;
  logic                              fault_q;
  logic                              irq_q;
  logic [7:0]                        ram_q [RAM_DEPTH];
  serial_channel_pkg::engine_state_t state_q;
  logic                              chanEn;
  logic                              orderLsb;
  logic                              autoMode;
  logic                              internalClk;
  logic                              tick;
  logic                              fallEdge;
  logic                              riseEdge;
  logic                              lastRise;
  logic                              rxBit;
  logic                              wrShift;
  logic                              wrRamHit;
  logic                              ivlEn;
  logic                              waitBusy;
  logic                              gapEnd;

  // bus path reversal for lsb-first order
  function automatic logic [7:0] busOrder(input logic [7:0] v,
                                          input logic lsb);
    logic [7:0] r;
    r = v;
    if (lsb) begin
      for (int i = 0; i < 8; i++) begin
        r[i] = v[7-i];
      end
    end
    return r;
  endfunction

  function automatic logic ramHit(input logic [15:0] a);
    return a >= serial_channel_pkg::ADDR_RAM_BASE &&
           a < serial_channel_pkg::ADDR_RAM_BASE + 16'h0040;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // reset release, asserted asynchronously
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rstMeta_q <= 1'b0;
      rstN      <= 1'b0;
    end else begin
      rstMeta_q <= 1'b1;
      rstN      <= rstMeta_q;
    end
  end

  pin_sync #(.WIDTH(3)) pinSyncInst (
    .clk     (clk),
    .rstN    (rstN),
    .asyncIn ({busyPinIn, serialInPin, serialClockPinIn}),
    .syncOut (pinSync)
  );

  assign sckSync  = pinSync[0];
  assign siSync   = pinSync[1];
  assign busySync = pinSync[2];

  ////////////////////////////////////////////////////////////////////////
  assign chanEn   = mode_q[serial_channel_pkg::MODE_ENABLE_BIT];
  assign orderLsb = mode_q[serial_channel_pkg::MODE_ORDER_BIT];
  assign autoMode = mode_q[serial_channel_pkg::MODE_AUTO_BIT];
  assign ivlEn    = interval_q[serial_channel_pkg::IVL_ENABLE_BIT];
  assign internalClk = mode_q[serial_channel_pkg::MODE_CLKHI_BIT];
  assign tick = mode_q[serial_channel_pkg::MODE_CLKLO_BIT] ?
                prescalerTick : timerTwoTick;
  assign fallEdge = (state_q == serial_channel_pkg::ST_SHIFT) &&
                    (internalClk ? (tick && sckInt_q)
                                 : (sckPrev_q && !sckSync));
  assign riseEdge = (state_q == serial_channel_pkg::ST_SHIFT) &&
                    (internalClk ? (tick && !sckInt_q)
                                 : (!sckPrev_q && sckSync));
  assign lastRise = riseEdge &&
                    bitCnt_q == serial_channel_pkg::BITS_PER_FRAME - 4'h1;
  assign rxBit = (!autoMode ||
                  control_q[serial_channel_pkg::CTRL_RX_BIT]) && siSync;
  assign wrShift  = wrStrobe && addr == serial_channel_pkg::ADDR_SHIFT;
  assign wrRamHit = wrStrobe && ramHit(addr);
  // busy control is void while the interval is programmed
  assign waitBusy = control_q[serial_channel_pkg::CTRL_WAIT_BIT] && !ivlEn;
  assign gapEnd   = gapCnt_q == 16'h0000 && !(waitBusy && busySync);
  assign gapLoad  = ivlEn ?
    16'((int'(interval_q[4:0]) + 1) * GAP_UNIT_CYC + GAP_BASE_CYC) :
    serial_channel_pkg::GAP_FREE_CYC;

  ////////////////////////////////////////////////////////////////////////
  // registers clear at reset
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      mode_q     <= serial_channel_pkg::MODE_RESET;
      interval_q <= serial_channel_pkg::INTERVAL_RESET;
    end else if (wrStrobe) begin
      if (addr == serial_channel_pkg::ADDR_MODE) begin
        mode_q <= wrData & serial_channel_pkg::MODE_WRITE_MASK;
      end else if (addr == serial_channel_pkg::ADDR_INTERVAL) begin
        interval_q <= wrData & serial_channel_pkg::IVL_WRITE_MASK;
      end
    end
  end

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      control_q <= serial_channel_pkg::CONTROL_RESET;
    end else if (wrStrobe && addr == serial_channel_pkg::ADDR_CONTROL) begin
      control_q <= wrData & serial_channel_pkg::CTRL_WRITE_MASK;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // start only from a stopped clock
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      state_q <= serial_channel_pkg::ST_IDLE;
    end else if (!chanEn) begin
      state_q <= serial_channel_pkg::ST_IDLE;
    end else begin
      case (state_q)
        serial_channel_pkg::ST_IDLE: begin
          if (wrShift) begin
            state_q <= autoMode ? serial_channel_pkg::ST_LOAD
                                : serial_channel_pkg::ST_SHIFT;
          end
        end
        serial_channel_pkg::ST_LOAD: begin
          state_q <= serial_channel_pkg::ST_SHIFT;
        end
        serial_channel_pkg::ST_SHIFT: begin
          if (lastRise) begin
            state_q <= autoMode ? serial_channel_pkg::ST_DONE
                                : serial_channel_pkg::ST_IDLE;
          end
        end
        serial_channel_pkg::ST_DONE: begin
          state_q <= (pointer_q == 6'h00) ? serial_channel_pkg::ST_IDLE
                                          : serial_channel_pkg::ST_GAP;
        end
        serial_channel_pkg::ST_GAP: begin
          if (gapEnd) begin
            state_q <= serial_channel_pkg::ST_LOAD;
          end
        end
        default: begin
          state_q <= serial_channel_pkg::ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      bitCnt_q <= 4'h0;
    end else if (!chanEn || state_q != serial_channel_pkg::ST_SHIFT) begin
      bitCnt_q <= 4'h0;
    end else if (riseEdge) begin
      bitCnt_q <= bitCnt_q + 4'h1;
    end
  end

  // internal serial clock idles high
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      sckInt_q  <= 1'b1;
      sckPrev_q <= 1'b1;
    end else begin
      sckPrev_q <= sckSync;
      if (state_q != serial_channel_pkg::ST_SHIFT) begin
        sckInt_q <= 1'b1;
      end else if (internalClk && tick) begin
        sckInt_q <= !sckInt_q;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // shift register and output latch
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      shift_q <= 8'h00;
    end else if (wrShift && !autoMode &&
                 state_q == serial_channel_pkg::ST_IDLE) begin
      shift_q <= busOrder(wrData, orderLsb);
    end else if (state_q == serial_channel_pkg::ST_LOAD) begin
      shift_q <= busOrder(ram_q[pointer_q], orderLsb);
    end else if (riseEdge) begin
      shift_q <= {shift_q[6:0], rxBit};
    end
  end

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      soLatch_q <= 1'b0;
    end else if (wrShift && state_q == serial_channel_pkg::ST_IDLE) begin
      soLatch_q <= 1'b0;
    end else if (fallEdge) begin
      soLatch_q <= shift_q[7];
    end else if (state_q == serial_channel_pkg::ST_DONE &&
                 pointer_q == 6'h00) begin
      soLatch_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // buffer, software and engine share it
  always_ff @(posedge clk) begin
    if (state_q == serial_channel_pkg::ST_DONE &&
        control_q[serial_channel_pkg::CTRL_RX_BIT]) begin
      ram_q[pointer_q] <= busOrder(shift_q, orderLsb);
    end else if (wrRamHit) begin
      ram_q[addr[5:0]] <= wrData;
    end
  end

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      pointer_q <= 6'h00;
    end else if (state_q == serial_channel_pkg::ST_DONE &&
                 pointer_q != 6'h00) begin
      pointer_q <= pointer_q - 6'h01;
    end else if (wrStrobe && addr == serial_channel_pkg::ADDR_POINTER &&
                 state_q == serial_channel_pkg::ST_IDLE) begin
      pointer_q <= wrData[5:0];
    end
  end

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      gapCnt_q    <= 16'h0000;
      strobeCnt_q <= 4'h0;
    end else if (state_q == serial_channel_pkg::ST_DONE) begin
      // free gap when interval is off
      gapCnt_q    <= gapLoad;
      strobeCnt_q <= control_q[serial_channel_pkg::CTRL_STROBE_BIT] ?
                     serial_channel_pkg::STROBE_CYC : 4'h0;
    end else begin
      if (gapCnt_q != 16'h0000) begin
        gapCnt_q <= gapCnt_q - 16'h0001;
      end
      if (strobeCnt_q != 4'h0) begin
        strobeCnt_q <= strobeCnt_q - 4'h1;
      end
    end
  end

  // transfer flag; fault on busy at byte end
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      xfer_q  <= 1'b0;
      fault_q <= 1'b0;
    end else if (!chanEn) begin
      xfer_q <= 1'b0;
    end else if (wrShift && autoMode &&
                 state_q == serial_channel_pkg::ST_IDLE) begin
      xfer_q  <= 1'b1;
      fault_q <= 1'b0;
    end else if (state_q == serial_channel_pkg::ST_DONE) begin
      if (pointer_q == 6'h00) begin
        xfer_q <= 1'b0;
      end
      if (waitBusy && busySync) begin
        fault_q <= 1'b1;
      end
    end
  end

  // irq flag, a set beats a same-cycle clear
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      irq_q <= 1'b0;
    end else if ((lastRise && !autoMode) ||
                 (state_q == serial_channel_pkg::ST_DONE &&
                  pointer_q == 6'h00)) begin
      irq_q <= 1'b1;
    end else if (wrStrobe && addr == serial_channel_pkg::ADDR_STATUS &&
                 wrData[serial_channel_pkg::STAT_IRQ_BIT]) begin
      irq_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // read data valid only in the cycle after the strobe
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      rdData <= 8'h00;
    end else if (!rdStrobe) begin
      rdData <= 8'h00;
    end else if (addr == serial_channel_pkg::ADDR_MODE) begin
      rdData <= mode_q;
    end else if (addr == serial_channel_pkg::ADDR_SHIFT) begin
      rdData <= busOrder(shift_q, orderLsb);
    end else if (addr == serial_channel_pkg::ADDR_CONTROL) begin
      rdData <= {control_q[7:5], fault_q, xfer_q, control_q[2:0]};
    end else if (addr == serial_channel_pkg::ADDR_INTERVAL) begin
      rdData <= interval_q;
    end else if (addr == serial_channel_pkg::ADDR_POINTER) begin
      rdData <= {2'h0, pointer_q};
    end else if (addr == serial_channel_pkg::ADDR_STATUS) begin
      rdData <= {7'h00, irq_q};
    end else if (ramHit(addr)) begin
      rdData <= ram_q[addr[5:0]];
    end else begin
      rdData <= 8'h00;
    end
  end

  always_comb begin
    pinsOut.sck      = sckInt_q;
    pinsOut.sckOe    = chanEn && internalClk;
    pinsOut.so       = soLatch_q;
    pinsOut.soOe     = chanEn;
    pinsOut.strobe   = strobeCnt_q != 4'h0;
    pinsOut.strobeOe = chanEn && autoMode &&
                       control_q[serial_channel_pkg::CTRL_STROBE_BIT];
  end

  assign channelIrqFlag = irq_q;

  ////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstN);

  sequence idleWrite;
    wrShift && chanEn && state_q == serial_channel_pkg::ST_IDLE;
  endsequence

  sequence lastByteDone;
    state_q == serial_channel_pkg::ST_DONE && pointer_q == 6'h00;
  endsequence

  start_on_write_a: assert property (
    idleWrite |=> state_q != serial_channel_pkg::ST_IDLE)
    else $error("enabled write did not start");

  no_start_off_a: assert property (
    !chanEn ##1 chanEn && !wrShift |=>
    state_q == serial_channel_pkg::ST_IDLE)
    else $error("started after late enable");

  so_low_write_a: assert property (
    idleWrite |=> !pinsOut.so)
    else $error("serial out not low after write");

  irq_after_eight_a: assert property (
    lastRise && !autoMode |=>
    irq_q && state_q == serial_channel_pkg::ST_IDLE)
    else $error("irq or stop missing after frame");

  disabled_quiet_a: assert property (
    !chanEn |-> !pinsOut.soOe && !pinsOut.sckOe ##1 bitCnt_q == 4'h0)
    else $error("pins or counter active while off");

  rx_off_zero_a: assert property (
    riseEdge && autoMode && !control_q[serial_channel_pkg::CTRL_RX_BIT]
    |=> !shift_q[0])
    else $error("serial in read while rx off");

  pointer_step_a: assert property (
    state_q == serial_channel_pkg::ST_DONE && pointer_q != 6'h00
    |=> pointer_q == $past(pointer_q) - 6'h01)
    else $error("pointer did not decrement");

  xfer_clear_a: assert property (
    lastByteDone |=> !xfer_q && irq_q)
    else $error("transfer flag not cleared at end");

  gap_length_a: assert property (
    state_q == serial_channel_pkg::ST_DONE && pointer_q != 6'h00 && ivlEn
    |=> gapCnt_q == 16'((int'(interval_q[4:0]) + 1) * GAP_UNIT_CYC
                        + GAP_BASE_CYC))
    else $error("interval gap length wrong");

  free_gap_a: assert property (
    state_q == serial_channel_pkg::ST_DONE && pointer_q != 6'h00 && !ivlEn
    |=> gapCnt_q == serial_channel_pkg::GAP_FREE_CYC)
    else $error("gap inserted with interval off");

endmodule // serial_channel

// ---- testbench/serial_peer.sv ----
// peripheral model on the far side of the serial pins
module serial_peer (
  // serial clock and data from the channel, and reset
  input  wire logic       sck,
  input  wire logic       sckOe,
  input  wire logic       so,
  input  wire logic       rstN,
  // byte to send back
  input  wire logic [7:0] txByte,
  // data toward the channel, and the byte received from it
  output      logic       si,
  output      logic [7:0] rxByte
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] bitCnt;
  logic       siBit;
  // released line flips so a stale level never passes
  assign si = sckOe ? siBit : ~siBit;
  always @(negedge sck or negedge rstN) begin
    if (!rstN) siBit <= 1'b0;
    else siBit <= txByte[3'h7 - bitCnt];
  end
  always @(posedge sck or negedge rstN) begin
    if (!rstN) begin
      bitCnt <= 3'h0;
      rxByte <= 8'h00;
    end else begin
      bitCnt <= bitCnt + 3'h1;
      rxByte <= {rxByte[6:0], so};
    end
  end
endmodule // serial_peer

// ---- testbench/testbench.sv ----
// self-checking bench for the three-wire serial channel
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [15:0] addr = 16'h0000;
  logic [7:0]  wrData = 8'h00;
  logic        wrStrobe = 1'b0;
  logic        rdStrobe = 1'b0;
  logic        timerTwoTick = 1'b0;
  logic [2:0]  tickCnt = 3'h0;
  logic        preTick = 1'b0;
  logic [7:0]  rdData;
  logic [7:0]  peerRx;
  logic        siPin;
  logic        channelIrqFlag;
  serial_channel_pkg::serial_pins_out_t pinsOut;
  int nFail = 0;
  int totalChecks = 0;
  always #12.5 clk = ~clk;
  // slow tick keeps the pin synchronisers well ahead
  always @(posedge clk) begin
    tickCnt <= tickCnt + 3'h1;
    timerTwoTick <= (tickCnt == 3'h7);
    preTick <= (tickCnt == 3'h3);
  end
  serial_channel #(.GAP_UNIT_CYC(4), .GAP_BASE_CYC(2)) dut_u (
    .clk(clk), .rst_n(rst_n), .addr(addr), .wrData(wrData),
    .wrStrobe(wrStrobe), .rdStrobe(rdStrobe), .rdData(rdData),
    .timerTwoTick(timerTwoTick), .prescalerTick(preTick),
    .serialClockPinIn(1'b1), .serialInPin(siPin), .busyPinIn(1'b0),
    .pinsOut(pinsOut), .channelIrqFlag(channelIrqFlag));
  serial_peer peer_u (
    .sck(pinsOut.sck), .sckOe(pinsOut.sckOe), .so(pinsOut.so),
    .rstN(rst_n), .txByte(8'h35), .si(siPin), .rxByte(peerRx));
  ////////////////////////////////////////////////////////////////////
  task automatic giveVerdict();
    $display("checks %0d mismatches %0d", totalChecks, nFail);
    if (nFail == 0 && totalChecks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    totalChecks++;
    if (seen !== exp) begin
      nFail++;
      $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wrData <= d;
    wrStrobe <= 1'b1;
    @(posedge clk);
    wrStrobe <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [15:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rdStrobe <= 1'b1;
    @(posedge clk);
    rdStrobe <= 1'b0;
    #1 d = rdData;
  endtask
  ////////////////////////////////////////////////////////////////////
  task automatic test_reset();
    logic [7:0] v;
    rd(serial_channel_pkg::ADDR_MODE, v);
    check(v, 8'h00);
    rd(serial_channel_pkg::ADDR_CONTROL, v);
    check(v, 8'h00);
    rd(serial_channel_pkg::ADDR_INTERVAL, v);
    check(v, 8'h00);
    wr(serial_channel_pkg::ADDR_CONTROL, 8'h18);
    rd(serial_channel_pkg::ADDR_CONTROL, v);
    check(v, 8'h00);
    $display("reset test done");
  endtask
  task automatic test_disabled();
    wr(serial_channel_pkg::ADDR_MODE, 8'h02);
    wr(serial_channel_pkg::ADDR_SHIFT, 8'h0f);
    check({7'h00, pinsOut.soOe}, 8'h00);
    wr(serial_channel_pkg::ADDR_MODE, 8'h82);
    repeat (200) @(posedge clk);
    check({7'h00, channelIrqFlag}, 8'h00);
    $display("late enable test done");
  endtask
  task automatic xfer(input logic [7:0] mode, input logic [7:0] data,
                      input logic [7:0] expRx, input logic [7:0] expRd);
    logic [7:0] v;
    int i;
    wr(serial_channel_pkg::ADDR_MODE, mode);
    wr(serial_channel_pkg::ADDR_SHIFT, data);
    check({7'h00, pinsOut.so}, 8'h00);
    for (i = 0; i < 400 && channelIrqFlag !== 1'b1; i++) @(posedge clk);
    check({7'h00, channelIrqFlag}, 8'h01);
    if (i == 400) giveVerdict();
    repeat (2) @(posedge clk);
    check({7'h00, pinsOut.sck}, 8'h01);
    check(peerRx, expRx);
    rd(serial_channel_pkg::ADDR_SHIFT, v);
    check(v, expRd);
    wr(serial_channel_pkg::ADDR_STATUS, 8'h01);
    check({7'h00, channelIrqFlag}, 8'h00);
    $display("transfer test done, mode %h", mode);
  endtask
  task automatic test_auto(input logic [7:0] ctrl, input logic [7:0] ivl,
                           input logic [7:0] exp1, input logic [7:0] exp0);
    logic [7:0] v;
    int i;
    logic sawStb;
    sawStb = 1'b0;
    wr(serial_channel_pkg::ADDR_RAM_BASE, 8'h5a);
    wr(serial_channel_pkg::ADDR_RAM_BASE + 16'h0001, 8'hc3);
    wr(serial_channel_pkg::ADDR_POINTER, 8'h01);
    wr(serial_channel_pkg::ADDR_CONTROL, ctrl);
    wr(serial_channel_pkg::ADDR_INTERVAL, ivl);
    // handshakes only beside the internal clock
    wr(serial_channel_pkg::ADDR_MODE, 8'ha2);
    wr(serial_channel_pkg::ADDR_SHIFT, 8'h00);
    for (i = 0; i < 600 && channelIrqFlag !== 1'b1; i++) begin
      @(posedge clk);
      sawStb |= pinsOut.strobe;
    end
    check({7'h00, channelIrqFlag}, 8'h01);
    if (i == 600) giveVerdict();
    check({7'h00, sawStb}, 8'h01);
    check(peerRx, 8'h5a);
    rd(serial_channel_pkg::ADDR_CONTROL, v);
    check(v, ctrl);
    rd(serial_channel_pkg::ADDR_POINTER, v);
    check(v, 8'h00);
    rd(serial_channel_pkg::ADDR_RAM_BASE + 16'h0001, v);
    check(v, exp1);
    rd(serial_channel_pkg::ADDR_RAM_BASE, v);
    check(v, exp0);
    wr(serial_channel_pkg::ADDR_STATUS, 8'h01);
    $display("auto test done, control %h", ctrl);
  endtask
  initial begin
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    test_reset();
    test_disabled();
    xfer(8'h82, 8'ha5, 8'ha5, 8'h35);
    xfer(8'hc2, 8'h01, 8'h80, 8'hac);
    xfer(8'h83, 8'h3c, 8'h3c, 8'h35);
    test_auto(8'h84, 8'h00, 8'h35, 8'h35);
    test_auto(8'h04, 8'h80, 8'hc3, 8'h5a);
    giveVerdict();
  end
endmodule // testbench
